// ==== rsd_exec.sv ====
// Execution slice for rotate through carry, subtract with borrow and decrement with skip.
// Behaviour
// - Rotate: accumulator bits 0-6 take operand bits 1-7, bit 7 takes old carry.
// - Rotate: carry takes operand bit 0; all other flags stay.
// - Rotate leaves the memory location untouched; only the accumulator and the carry change.
// - Subtracts compute accumulator minus operand minus inverted carry; update all four flags.
// - After subtract carry is 0 on negative difference, 1 on zero or positive.
// - Accumulator-destination subtract writes accumulator, leaves memory unchanged.
// - Memory-destination subtract writes memory, leaves accumulator unchanged.
// - Decrement-skip writes operand minus one to memory, skips on zero, no flags.
// - A skip inserts one dummy cycle, making the instruction two cycles long.
// - A nonzero decrement result does not skip; execution continues normally.
// - Accumulator-destination decrement writes accumulator, keeps memory, same skip test.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
module rsd_exec (
  // Clock and reset.
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  // Instruction issue from the sequencer.
  input  wire logic                                exec_valid,
  output logic                                     exec_ready,
  input  wire rsd_pkg::rsd_req_s                   exec_req,
  // Data memory write-back and sequencer feedback.
  output rsd_pkg::rsd_mem_wr_s                     mem_wr,
  output logic                                     skip,
  output logic                                     dummy_cycle,
  // State seen by the rest of the core.
  output logic [rsd_pkg::DATA_W-1:0]               accumulator,
  output rsd_pkg::rsd_flags_s                      flags,
  // AXI4-Lite write address channel.
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [rsd_pkg::AXI_AW-1:0]          s_axi_awaddr,
  // AXI4-Lite write data channel.
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  input  wire logic [rsd_pkg::AXI_DW-1:0]          s_axi_wdata,
  input  wire logic [rsd_pkg::AXI_DW/8-1:0]        s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  output logic [1:0]                               s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  input  wire logic [rsd_pkg::AXI_AW-1:0]          s_axi_araddr,
  // AXI4-Lite read data channel.
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output logic [rsd_pkg::AXI_DW-1:0]               s_axi_rdata,
  output logic [1:0]                               s_axi_rresp
);

  // Subtract with borrow; carry out of the inverted-operand sum means no borrow.
  function automatic rsd_pkg::rsd_sub_s sub_borrow(
    input logic [rsd_pkg::DATA_W-1:0] a,
    input logic [rsd_pkg::DATA_W-1:0] m,
    input logic                       cin
  );
    logic [rsd_pkg::DATA_W:0]     full;
    logic [rsd_pkg::NIBBLE_W:0]   low;
    rsd_pkg::rsd_sub_s            r;
    full = {1'b0, a} + {1'b0, ~m} + {{rsd_pkg::DATA_W{1'b0}}, cin};
    low  = {1'b0, a[rsd_pkg::NIBBLE_W-1:0]} + {1'b0, ~m[rsd_pkg::NIBBLE_W-1:0]}
           + {{rsd_pkg::NIBBLE_W{1'b0}}, cin};
    r.res                  = full[rsd_pkg::DATA_W-1:0];
    r.flags.c              = full[rsd_pkg::DATA_W];
    r.flags.aux_carry_flag = low[rsd_pkg::NIBBLE_W];
    r.flags.z              = (full[rsd_pkg::DATA_W-1:0] == '0);
    r.flags.overflow_flag  = (a[rsd_pkg::DATA_W-1] != m[rsd_pkg::DATA_W-1])
                             && (full[rsd_pkg::DATA_W-1] != a[rsd_pkg::DATA_W-1]);
    return r;
  endfunction

  // Register read decode; unmapped addresses answer zero.
  function automatic logic [rsd_pkg::AXI_DW-1:0] read_mux(
    input logic [rsd_pkg::AXI_AW-1:0]  addr,
    input logic [rsd_pkg::DATA_W-1:0]  accum_v,
    input rsd_pkg::rsd_flags_s         fl_v,
    input logic                        dummy_v,
    input logic                        skip_v,
    input logic                        en_v
  );
    logic [rsd_pkg::AXI_DW-1:0] d;
    d = '0;
    if (addr == rsd_pkg::REG_ACCUM)
    begin
      d[rsd_pkg::DATA_W-1:0] = accum_v;
    end
    else if (addr == rsd_pkg::REG_FLAGS)
    begin
      d[rsd_pkg::FLAG_C_BIT]   = fl_v.c;
      d[rsd_pkg::FLAG_AUX_BIT] = fl_v.aux_carry_flag;
      d[rsd_pkg::FLAG_Z_BIT]   = fl_v.z;
      d[rsd_pkg::FLAG_OVF_BIT] = fl_v.overflow_flag;
    end
    else if (addr == rsd_pkg::REG_STATUS)
    begin
      d[rsd_pkg::STAT_DUMMY_BIT] = dummy_v;
      d[rsd_pkg::STAT_SKIP_BIT]  = skip_v;
    end
    else if (addr == rsd_pkg::REG_CTRL)
    begin
      d[rsd_pkg::CTRL_EN_BIT] = en_v;
    end
    return d;
  endfunction

  function automatic logic is_mapped(input logic [rsd_pkg::AXI_AW-1:0] addr);
    return (addr == rsd_pkg::REG_ACCUM) || (addr == rsd_pkg::REG_FLAGS)
           || (addr == rsd_pkg::REG_STATUS) || (addr == rsd_pkg::REG_CTRL);
  endfunction

  // Bus slave state.
  logic                       aw_held;
  logic [rsd_pkg::AXI_AW-1:0] aw_addr;
  logic                       w_held;
  logic [rsd_pkg::AXI_DW-1:0] w_data;
  logic                       w_lane0;
  logic                       next_aw_held;
  logic [rsd_pkg::AXI_AW-1:0] next_aw_addr;
  logic                       next_w_held;
  logic [rsd_pkg::AXI_DW-1:0] next_w_data;
  logic                       next_w_lane0;
  logic                       next_bvalid;
  logic [1:0]                 next_bresp;
  logic                       next_rvalid;
  logic [rsd_pkg::AXI_DW-1:0] next_rdata;
  logic [1:0]                 next_rresp;
  logic                       wr_fire;
  logic [rsd_pkg::AXI_AW-1:0] wr_addr;
  logic [rsd_pkg::AXI_DW-1:0] wr_data;
  logic                       wr_lane0;

  // Core state.
  rsd_pkg::rsd_state_e        state;
  rsd_pkg::rsd_state_e        next_state;
  logic                       enable;
  logic                       next_enable;
  logic [rsd_pkg::DATA_W-1:0] next_accumulator;
  rsd_pkg::rsd_flags_s        next_flags;
  rsd_pkg::rsd_mem_wr_s       next_mem_wr;
  logic                       next_skip;
  rsd_pkg::rsd_sub_s          sub;
  logic [rsd_pkg::DATA_W-1:0] dec;
  logic                       taken;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // No new instruction is taken while the dummy slot of a skip is running.
  assign exec_ready    = enable && (state == rsd_pkg::st_run);
  assign taken         = exec_valid && exec_ready;
  assign dummy_cycle   = (state == rsd_pkg::st_dummy);

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    wr_fire  = aw_held && w_held && !s_axi_bvalid;
    wr_addr  = aw_addr;
    wr_data  = w_data;
    wr_lane0 = w_lane0;
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(aw_addr) ? rsd_pkg::RESP_OKAY : rsd_pkg::RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = read_mux(s_axi_araddr, accumulator, flags, dummy_cycle, skip, enable);
      next_rresp  = is_mapped(s_axi_araddr) ? rsd_pkg::RESP_OKAY : rsd_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= '0;
      w_held       <= 1'b0;
      w_data       <= '0;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rsd_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= rsd_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_lane0      <= next_w_lane0;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // Software writes are applied first so that an instruction in the same cycle wins.
  always_comb
  begin
    next_state       = rsd_pkg::st_run;
    next_enable      = enable;
    next_accumulator = accumulator;
    next_flags       = flags;
    next_mem_wr      = '{we: 1'b0, data: mem_wr.data};
    next_skip        = 1'b0;
    sub              = sub_borrow(accumulator, exec_req.operand, flags.c);
    dec              = exec_req.operand - rsd_pkg::DEC_STEP;
    if (wr_fire && wr_lane0)
    begin
      if (wr_addr == rsd_pkg::REG_ACCUM)
      begin
        next_accumulator = wr_data[rsd_pkg::DATA_W-1:0];
      end
      else if (wr_addr == rsd_pkg::REG_FLAGS)
      begin
        next_flags.c              = wr_data[rsd_pkg::FLAG_C_BIT];
        next_flags.aux_carry_flag = wr_data[rsd_pkg::FLAG_AUX_BIT];
        next_flags.z              = wr_data[rsd_pkg::FLAG_Z_BIT];
        next_flags.overflow_flag  = wr_data[rsd_pkg::FLAG_OVF_BIT];
      end
      else if (wr_addr == rsd_pkg::REG_CTRL)
      begin
        next_enable = wr_data[rsd_pkg::CTRL_EN_BIT];
      end
    end
    if (taken)
    begin
      unique case (exec_req.op)
        rsd_pkg::rotate_right_carry_to_acc:
        begin
          next_accumulator = {flags.c, exec_req.operand[rsd_pkg::DATA_W-1:1]};
          next_flags.c     = exec_req.operand[0];
        end
        rsd_pkg::subtract_borrow_to_acc:
        begin
          next_accumulator = sub.res;
          next_flags       = sub.flags;
        end
        rsd_pkg::subtract_borrow_to_mem:
        begin
          next_mem_wr = '{we: 1'b1, data: sub.res};
          next_flags  = sub.flags;
        end
        rsd_pkg::decrement_skip_zero_mem:
        begin
          next_mem_wr = '{we: 1'b1, data: dec};
          next_skip   = (dec == '0);
        end
        rsd_pkg::decrement_skip_zero_acc:
        begin
          next_accumulator = dec;
          next_skip        = (dec == '0);
        end
        default:
        begin
          next_skip = 1'b0;
        end
      endcase
      // Only a skipping decrement earns the dummy slot; the others stay single cycle.
      if (next_skip)
      begin
        next_state = rsd_pkg::st_dummy;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state       <= rsd_pkg::st_run;
      enable      <= rsd_pkg::EN_RST;
      accumulator <= rsd_pkg::ACCUM_RST;
      flags       <= '0;
      mem_wr      <= '0;
      skip        <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      enable      <= next_enable;
      accumulator <= next_accumulator;
      flags       <= next_flags;
      mem_wr      <= next_mem_wr;
      skip        <= next_skip;
    end
  end

endmodule

// ==== rsd_pkg.sv ====
// Package with constants, types and register map of the rotate, subtract and decrement slice.
package rsd_pkg;

  // Data widths.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;

  // Register byte addresses.
  localparam logic [AXI_AW-1:0] REG_ACCUM  = 8'h00;
  localparam logic [AXI_AW-1:0] REG_FLAGS  = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] REG_CTRL   = 8'h0C;

  // Field positions and the nibble width.
  localparam int unsigned FLAG_C_BIT     = 0;
  localparam int unsigned FLAG_AUX_BIT   = 1;
  localparam int unsigned FLAG_Z_BIT     = 2;
  localparam int unsigned FLAG_OVF_BIT   = 3;
  localparam int unsigned STAT_DUMMY_BIT = 0;
  localparam int unsigned STAT_SKIP_BIT  = 1;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned NIBBLE_W       = 4;

  // Reset values and the decrement step.
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic              EN_RST    = 1'b1;
  localparam logic [DATA_W-1:0] DEC_STEP  = 8'h01;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    rotate_right_carry_to_acc,
    subtract_borrow_to_acc,
    subtract_borrow_to_mem,
    decrement_skip_zero_mem,
    decrement_skip_zero_acc
  } rsd_op_e;

  typedef enum logic {
    st_run,
    st_dummy
  } rsd_state_e;

  typedef struct packed {
    logic overflow_flag;
    logic z;
    logic aux_carry_flag;
    logic c;
  } rsd_flags_s;

  typedef struct packed {
    rsd_op_e           op;
    logic [DATA_W-1:0] operand;
  } rsd_req_s;

  typedef struct packed {
    logic              we;
    logic [DATA_W-1:0] data;
  } rsd_mem_wr_s;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    rsd_flags_s        flags;
  } rsd_sub_s;

endpackage

// ==== rsd_exec_sva.sv ====
// Concurrent checks on the instruction side of the execution slice.
module rsd_exec_sva (
  // Clock and reset.
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // Instruction side.
  input wire logic                       exec_valid,
  input wire logic                       exec_ready,
  input wire rsd_pkg::rsd_req_s          exec_req,
  input wire rsd_pkg::rsd_mem_wr_s       mem_wr,
  input wire logic                       skip,
  input wire logic                       dummy_cycle,
  input wire logic [rsd_pkg::DATA_W-1:0] accumulator,
  input wire rsd_pkg::rsd_flags_s        flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       take;
  logic [7:0] diff;
  logic       no_borrow;
  logic [2:0] opc;
  // Reference difference is formed from the pre-edge state, so $past sees it directly.
  assign take      = exec_valid && exec_ready;
  assign opc       = exec_req.op;
  assign diff      = accumulator - exec_req.operand - {7'h00, !flags.c};
  assign no_borrow = {1'h0, accumulator} >= ({1'h0, exec_req.operand} + {8'h00, !flags.c});
  rot_accum_a: assert property (
    take && opc == 3'h0 |=> accumulator == {$past(flags.c), $past(exec_req.operand[7:1])}
      && !mem_wr.we) else $error("rotate result wrong");
  rot_flag_a: assert property (
    take && opc == 3'h0 |=> {flags[3:1], flags.c} == {$past(flags[3:1]), $past(exec_req.operand[0])})
    else $error("rotate flags wrong");
  sub_flag_a: assert property (
    take && (opc == 3'h1 || opc == 3'h2) |=> flags.c == $past(no_borrow)
      && flags.z == ($past(diff) == 8'h00)) else $error("subtract flags wrong");
  sub_accum_a: assert property (
    take && opc == 3'h1 |=> accumulator == $past(diff) && !mem_wr.we)
    else $error("subtract to accumulator wrong");
  sub_mem_a: assert property (
    take && opc == 3'h2 |=> mem_wr.we && mem_wr.data == $past(diff) && $stable(accumulator))
    else $error("subtract to memory wrong");
  dec_mem_a: assert property (
    take && opc == 3'h3 |=> mem_wr.we && mem_wr.data == $past(exec_req.operand) - 8'h01
      && $stable(flags) && skip == ($past(exec_req.operand) == 8'h01))
    else $error("decrement to memory wrong");
  dec_accum_a: assert property (
    take && opc == 3'h4 |=> !mem_wr.we && accumulator == $past(exec_req.operand) - 8'h01
      && skip == ($past(exec_req.operand) == 8'h01)) else $error("decrement to accumulator wrong");
  skip_slot_a: assert property (
    skip |-> dummy_cycle && !exec_ready ##1 !dummy_cycle) else $error("dummy slot wrong");
  one_cycle_a: assert property (
    take && opc < 3'h3 |=> !skip && !dummy_cycle) else $error("unexpected dummy cycle");
endmodule

bind rsd_exec rsd_exec_sva u_sva (.ref_clk(ref_clk), .rst(rst), .exec_valid(exec_valid),
  .exec_ready(exec_ready), .exec_req(exec_req), .mem_wr(mem_wr), .skip(skip),
  .dummy_cycle(dummy_cycle), .accumulator(accumulator), .flags(flags));

// ==== rsd_seq_model.sv ====
// Behavioural sequencer that offers instructions to the slice.
module rsd_seq_model (
  // Clock.
  input  wire logic         ref_clk,
  // Instruction issue.
  input  wire logic         exec_ready,
  output logic              exec_valid,
  output rsd_pkg::rsd_req_s exec_req
);
  initial
  begin
    exec_valid <= 1'h0;
    exec_req   <= '0;
  end
  // Request is held until a ready edge, so a dummy slot just delays it.
  // The caller offers the next request or idles at that same edge, or it is taken twice.
  task automatic issue(input rsd_pkg::rsd_op_e code, input logic [7:0] opnd);
    exec_valid <= 1'h1;
    exec_req   <= '{op: code, operand: opnd};
    @(negedge ref_clk);
    while (!exec_ready)
      @(negedge ref_clk);
    @(posedge ref_clk);
  endtask
  // The stale operand is inverted so nothing can lean on it.
  task automatic idle();
    exec_valid       <= 1'h0;
    exec_req.operand <= ~exec_req.operand;
  endtask
endmodule

// ==== tb_rotate_subtract_decskip_exec.sv ====
// Self-checking bench for the rotate, subtract and decrement execution slice.
module tb_rotate_subtract_decskip_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk, rst, exec_valid, exec_ready, skip, dummy_cycle;
  rsd_pkg::rsd_req_s    exec_req;
  rsd_pkg::rsd_mem_wr_s mem_wr;
  rsd_pkg::rsd_flags_s  flags;
  logic [7:0]           accumulator, s_axi_awaddr, s_axi_araddr, a, o, r8, am;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                 s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, c;
  logic [31:0]          s_axi_wdata, s_axi_rdata;
  logic [3:0]           s_axi_wstrb, fl;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic [11:0]          r;
  logic [16:0]          sub_tab [6] = '{17'h0_A041, 17'h0_40A1, 17'h0_201E,
                                        17'h1_0003, 17'h0_FFFF, 17'h0_2609};
  logic [7:0]           dec_tab [3] = '{8'h01, 8'h00, 8'h05};
  int                   num_errors, checks, cycles, i;

  rsd_exec dut (.ref_clk, .rst, .exec_valid, .exec_ready, .exec_req, .mem_wr, .skip,
    .dummy_cycle, .accumulator, .flags, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  rsd_seq_model u_seq (.ref_clk, .exec_ready, .exec_valid, .exec_req);

  initial
  begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung handshake ends here rather than running forever.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh;
    @(posedge ref_clk);
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(negedge ref_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      @(posedge ref_clk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid && !ah) || (s_axi_wvalid && !wh));
    @(negedge ref_clk);
    while (!s_axi_bvalid) @(negedge ref_clk);
    cmp({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, er});
    @(posedge ref_clk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] ad, input logic [31:0] ex, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    @(negedge ref_clk);
    while (!s_axi_arready) @(negedge ref_clk);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'h0;
    @(negedge ref_clk);
    while (!s_axi_rvalid) @(negedge ref_clk);
    cmp(s_axi_rdata, ex);
    cmp({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, er});
    @(posedge ref_clk);
    s_axi_rready <= 1'h0;
  endtask

  // Write data is masked when no write happened, since it only holds its last value.
  // Results are checked mid-cycle after the take edge, while the next request already stands.
  task automatic run(input rsd_pkg::rsd_op_e code, input logic [7:0] opnd, input logic [7:0] ax,
                     input logic [3:0] fx, input logic wx, input logic [7:0] dx, input logic sx);
    u_seq.issue(code, opnd);
    fork
      begin
        @(negedge ref_clk);
        cmp({8'h00, accumulator, flags, mem_wr.we, mem_wr.we ? mem_wr.data : 8'h00, skip,
             dummy_cycle, exec_ready}, {8'h00, ax, fx, wx, dx, sx, sx, !sx});
      end
    join_none
  endtask

  function automatic logic [11:0] sub_ref(input logic [7:0] x, input logic [7:0] m, input logic k);
    logic [8:0] d;
    logic [4:0] n;
    d = {1'h0, x} - {1'h0, m} - {8'h00, !k};
    n = {1'h0, x[3:0]} - {1'h0, m[3:0]} - {4'h0, !k};
    return {d[7:0], (x[7] != m[7]) && (d[7] != x[7]), d[7:0] == 8'h00, !n[4], !d[8]};
  endfunction

  initial
  begin
    rst <= 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata  <= 32'h0000_0000;
    s_axi_wstrb  <= 4'hF;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    axi_rd(rsd_pkg::REG_FLAGS, 32'h0000_0000, rsd_pkg::RESP_OKAY);
    axi_rd(rsd_pkg::REG_CTRL, 32'h0000_0001, rsd_pkg::RESP_OKAY);
    axi_rd(8'h40, 32'h0000_0000, rsd_pkg::RESP_SLVERR);
    axi_wr(8'h40, 32'h0000_0055, rsd_pkg::RESP_SLVERR);
    for (i = 0; i < 2; i++)
    begin
      o = 8'hA4 | {7'h00, !i[0]};
      axi_wr(rsd_pkg::REG_FLAGS, {28'h000_0000, 3'h7, i[0]}, rsd_pkg::RESP_OKAY);
      run(rsd_pkg::rotate_right_carry_to_acc, o, {i[0], o[7:1]}, {3'h7, o[0]}, 1'h0, 8'h00, 1'h0);
      u_seq.idle();
    end
    for (i = 0; i < 6; i++)
    begin
      {a, o, c} = sub_tab[i];
      r = sub_ref(a, o, c);
      axi_wr(rsd_pkg::REG_ACCUM, {24'h00_0000, a}, rsd_pkg::RESP_OKAY);
      axi_wr(rsd_pkg::REG_FLAGS, {28'h000_0000, 3'h0, c}, rsd_pkg::RESP_OKAY);
      if (i[0])
        run(rsd_pkg::subtract_borrow_to_mem, o, a, r[3:0], 1'h1, r[11:4], 1'h0);
      else
        run(rsd_pkg::subtract_borrow_to_acc, o, r[11:4], r[3:0], 1'h0, 8'h00, 1'h0);
      u_seq.idle();
    end
    axi_rd(rsd_pkg::REG_ACCUM, 32'h0000_0013, rsd_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    axi_wr(rsd_pkg::REG_ACCUM, 32'h0000_00AA, rsd_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(rsd_pkg::REG_ACCUM, 32'h0000_0013, rsd_pkg::RESP_OKAY);
    // Back-to-back issue, so the request after a skip must wait out the dummy slot.
    am = 8'h13;
    fl = r[3:0];
    for (i = 0; i < 6; i++)
    begin
      o = dec_tab[i % 3];
      r8 = o - 8'h01;
      if (i < 3)
        run(rsd_pkg::decrement_skip_zero_mem, o, am, fl, 1'h1, r8, r8 == 8'h00);
      else
        run(rsd_pkg::decrement_skip_zero_acc, o, r8, fl, 1'h0, 8'h00, r8 == 8'h00);
      if (i >= 3) am = r8;
    end
    u_seq.idle();
    axi_wr(rsd_pkg::REG_CTRL, 32'h0000_0000, rsd_pkg::RESP_OKAY);
    @(negedge ref_clk);
    cmp({31'h0000_0000, exec_ready}, 32'h0000_0000);
    axi_wr(rsd_pkg::REG_CTRL, 32'h0000_0001, rsd_pkg::RESP_OKAY);
    axi_rd(rsd_pkg::REG_ACCUM, {24'h00_0000, am}, rsd_pkg::RESP_OKAY);
    axi_rd(rsd_pkg::REG_FLAGS, {28'h000_0000, fl}, rsd_pkg::RESP_OKAY);
    axi_rd(rsd_pkg::REG_STATUS, 32'h0000_0000, rsd_pkg::RESP_OKAY);
    print_verdict();
  end
endmodule
